// *** bms_pkg.sv ***
package bms_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_CLKCFG = 4'h4;
    localparam logic [3:0] REG_SCRATCH = 4'h8;
    localparam logic [3:0] REG_MODE = 4'hc;

    // ----------------------------------------------------------------
    // Private configuration memory layout
    // ----------------------------------------------------------------
    localparam int HART_COUNT = 5;
    localparam int CFG_WORDS = 8;
    localparam logic [2:0] CFG_BOOTMODE = 3'h0;
    localparam logic [2:0] CFG_VEC0 = 3'h1;
    localparam logic [2:0] CFG_REVOKE = 3'h6;
    localparam logic [2:0] CFG_SERIAL = 3'h7;

    // ----------------------------------------------------------------
    // Boot modes and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] MODE_NOBOOT = 8'h00;
    localparam logic [7:0] MODE_STANDARD = 8'h01;
    localparam logic [7:0] MODE_SECURE = 8'h02;
    localparam logic [7:0] CC_CLK_MHZ = 8'h50;
    localparam logic [1:0] CLK_SRC_SYSCTRL = 2'h0;
    localparam logic [63:0] LOOP_BASE = 64'h0000_0000_0100_0000;
    localparam logic [31:0] LOOP_CODE = 32'h0000_006f;
    localparam logic [3:0] CFG_CYCLES = 4'h8;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_CONFIG = 4'h0,
        ST_DISPATCH = 4'h1,
        ST_LOAD = 4'h2,
        ST_RUN = 4'h3,
        ST_CERT_WAIT = 4'h4,
        ST_SERIAL = 4'h5,
        ST_VERSION = 4'h6,
        ST_SIG_WAIT = 4'h7,
        ST_HASH_WAIT = 4'h8,
        ST_FAIL = 4'h9
    } bms_state_t;

    typedef enum logic [3:0] {
        FAIL_NONE = 4'h0,
        FAIL_MODE = 4'h1,
        FAIL_SERIAL = 4'h2,
        FAIL_REVOKED = 4'h3,
        FAIL_SIGNATURE = 4'h4,
        FAIL_HASH = 4'h5
    } bms_fail_t;

    typedef struct packed {
        logic [63:0] serial;
        logic [63:0] version;
        logic [383:0] ubl_hash;
        logic [383:0] sig_r;
        logic [383:0] sig_s;
        logic [383:0] content_hash;
        logic [HART_COUNT-1:0][63:0] vector;
    } bms_cert_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bms_bus_t;

endpackage : bms_pkg

// *** bms_sequencer.sv ***
// Function
// - Hold complex reset until configuration completes
// - Stored mode item alone selects start-up
// - Mode 0: loop code, vectors, flag cleared
// - Mode 0 release runs loop while flag zero
// - Config memory only bitstream-programmed, not visible; REG_MODE reads back the latched mode byte
// - Complex clock defaults 80MHz, system source
// - Standard boot only when mode equals 1
// - Config item gives five hart vectors
// - Copy vectors before releasing reset
// - Finally release reset into code memory
// - Secure: ECDSA check, harts stay unstarted
// - Authenticate only, never encrypt or decrypt
// - Use P-384 curve and base point
// - u1, u2, combined point x is check
// - Pass only when check equals r
// - Authenticated: monitor hart starts, then others
// - Nonzero serial field must match device serial
// - Nonzero version must reach revocation threshold
// - Loader hash must match certificate hash
// - Harts start at certificate vectors
//
// Decided for this implementation: the register offsets and the plain strobed port.
module bms_sequencer (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire bms_pkg::bms_bus_t bus,
    output logic [31:0] rdata,
    // Bitstream programming port
    input wire logic prog_we,
    input wire logic [2:0] prog_addr,
    input wire logic [63:0] prog_data,
    // Certificate from embedded code memory
    input wire logic cert_valid,
    input wire bms_pkg::bms_cert_t cert,
    // Signature engine
    output logic sig_req,
    input wire logic sig_done,
    input wire logic [383:0] sig_check_x,
    // Loader hash engine
    output logic hash_req,
    input wire logic hash_done,
    input wire logic [383:0] hash_value,
    // Monitor hart request to start application harts
    input wire logic app_release,
    // Core complex control
    output logic cc_reset,
    output logic [bms_pkg::HART_COUNT-1:0] hart_run,
    output logic [bms_pkg::HART_COUNT-1:0][63:0] hart_vector,
    output logic [31:0] loop_code,
    output logic loop_hold,
    output logic boot_from_code_mem,
    output logic [7:0] cc_clk_mhz,
    output logic [1:0] cc_clk_src
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        bms_pkg::bms_state_t st;
        bms_pkg::bms_fail_t fail;
        logic [bms_pkg::CFG_WORDS-1:0][63:0] cfg_mem;
        logic [3:0] cnt;
        logic [7:0] mode;
        logic [bms_pkg::HART_COUNT-1:0][63:0] vec;
        logic [bms_pkg::HART_COUNT-1:0] run;
        logic [31:0] loop;
        logic scratch;
        logic cc_rst;
        logic code_mem;
        logic sig_req;
        logic hash_req;
        logic [7:0] clk_mhz;
        logic [1:0] clk_src;
        logic [31:0] rdata;
    } bms_regs_t;

    bms_regs_t q;
    bms_regs_t n;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        n = q;
        n.rdata = 32'h0000_0000;
        n.sig_req = 1'b0;
        n.hash_req = 1'b0;

        // Config memory has no path from the register port at all
        if (prog_we) begin
            n.cfg_mem[prog_addr] = prog_data;
        end

        // Register reads; answer one cycle later, unmapped reads zero
        if (bus.rd) begin
            case (bus.addr)
                bms_pkg::REG_STATUS: begin
                    n.rdata = {21'h000000, q.code_mem, q.cc_rst,
                        q.run[0], q.fail, q.st};
                end
                bms_pkg::REG_CLKCFG: begin
                    n.rdata = {22'h000000, q.clk_src, q.clk_mhz};
                end
                bms_pkg::REG_SCRATCH: begin
                    n.rdata = {31'h00000000, q.scratch};
                end
                bms_pkg::REG_MODE: begin
                    n.rdata = {24'h000000, q.mode};
                end
                default: begin
                    n.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Register writes
        if (bus.wr) begin
            case (bus.addr)
                bms_pkg::REG_CLKCFG: begin
                    n.clk_mhz = bus.wdata[7:0];
                    n.clk_src = bus.wdata[9:8];
                end
                bms_pkg::REG_SCRATCH: begin
                    n.scratch = bus.wdata[0];
                end
                default: begin
                    n.scratch = q.scratch;
                end
            endcase
        end

        case (q.st)
            // --------------------------------------------------------
            // Configuration phase, complex held in reset
            // --------------------------------------------------------
            bms_pkg::ST_CONFIG: begin
                n.cc_rst = 1'b1;
                if (q.cnt == bms_pkg::CFG_CYCLES) begin
                    n.mode = q.cfg_mem[bms_pkg::CFG_BOOTMODE][7:0];
                    n.st = bms_pkg::ST_DISPATCH;
                end else begin
                    n.cnt = q.cnt + 4'h1;
                end
            end

            bms_pkg::ST_DISPATCH: begin
                case (q.mode)
                    bms_pkg::MODE_NOBOOT: begin
                        // Loop image and vectors already hold reset values
                        n.run = '1;
                        n.cc_rst = 1'b0;
                        n.st = bms_pkg::ST_RUN;
                    end
                    bms_pkg::MODE_STANDARD: begin
                        n.st = bms_pkg::ST_LOAD;
                    end
                    bms_pkg::MODE_SECURE: begin
                        n.st = bms_pkg::ST_CERT_WAIT;
                    end
                    default: begin
                        n.fail = bms_pkg::FAIL_MODE;
                        n.st = bms_pkg::ST_FAIL;
                    end
                endcase
            end

            // --------------------------------------------------------
            // Standard boot
            // --------------------------------------------------------
            bms_pkg::ST_LOAD: begin
                for (int h = 0; h < bms_pkg::HART_COUNT; h++) begin
                    n.vec[h] = q.cfg_mem[3'(h) + bms_pkg::CFG_VEC0];
                end
                n.code_mem = 1'b1;
                n.run = '1;
                n.cc_rst = 1'b0;
                n.st = bms_pkg::ST_RUN;
            end

            // --------------------------------------------------------
            // Secure boot; certificate is only checked, never ciphered
            // --------------------------------------------------------
            bms_pkg::ST_CERT_WAIT: begin
                if (cert_valid) begin
                    n.st = bms_pkg::ST_SERIAL;
                end
            end

            bms_pkg::ST_SERIAL: begin
                if (cert.serial != 64'h0 &&
                    cert.serial != q.cfg_mem[bms_pkg::CFG_SERIAL]) begin
                    n.fail = bms_pkg::FAIL_SERIAL;
                    n.st = bms_pkg::ST_FAIL;
                end else begin
                    n.st = bms_pkg::ST_VERSION;
                end
            end

            bms_pkg::ST_VERSION: begin
                if (cert.version != 64'h0 &&
                    cert.version < q.cfg_mem[bms_pkg::CFG_REVOKE]) begin
                    n.fail = bms_pkg::FAIL_REVOKED;
                    n.st = bms_pkg::ST_FAIL;
                end else begin
                    // Engine forms u1, u2 and the P-384 point from z, r, s
                    n.sig_req = 1'b1;
                    n.st = bms_pkg::ST_SIG_WAIT;
                end
            end

            bms_pkg::ST_SIG_WAIT: begin
                if (sig_done) begin
                    if (sig_check_x == cert.sig_r) begin
                        n.hash_req = 1'b1;
                        n.st = bms_pkg::ST_HASH_WAIT;
                    end else begin
                        n.fail = bms_pkg::FAIL_SIGNATURE;
                        n.st = bms_pkg::ST_FAIL;
                    end
                end
            end

            bms_pkg::ST_HASH_WAIT: begin
                if (hash_done) begin
                    if (hash_value == cert.ubl_hash) begin
                        n.vec = cert.vector;
                        n.code_mem = 1'b1;
                        n.run[0] = 1'b1;
                        n.cc_rst = 1'b0;
                        n.st = bms_pkg::ST_RUN;
                    end else begin
                        n.fail = bms_pkg::FAIL_HASH;
                        n.st = bms_pkg::ST_FAIL;
                    end
                end
            end

            // --------------------------------------------------------
            // Running; monitor hart brings up the others
            // --------------------------------------------------------
            bms_pkg::ST_RUN: begin
                if (app_release) begin
                    n.run = '1;
                end
            end

            // Only a fresh reset leaves this state
            bms_pkg::ST_FAIL: begin
                n.cc_rst = 1'b1;
                n.run = '0;
            end

            default: begin
                n.st = bms_pkg::ST_FAIL;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q.st <= bms_pkg::ST_CONFIG;
            q.fail <= bms_pkg::FAIL_NONE;
            // Non-volatile contents survive reset
            q.cfg_mem <= n.cfg_mem;
            q.cnt <= 4'h0;
            q.mode <= 8'h00;
            q.vec <= {bms_pkg::HART_COUNT{bms_pkg::LOOP_BASE}};
            q.run <= '0;
            q.loop <= bms_pkg::LOOP_CODE;
            q.scratch <= 1'b0;
            q.cc_rst <= 1'b1;
            q.code_mem <= 1'b0;
            q.sig_req <= 1'b0;
            q.hash_req <= 1'b0;
            q.clk_mhz <= bms_pkg::CC_CLK_MHZ;
            q.clk_src <= bms_pkg::CLK_SRC_SYSCTRL;
            q.rdata <= 32'h0000_0000;
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rdata = q.rdata;
    assign sig_req = q.sig_req;
    assign hash_req = q.hash_req;
    assign cc_reset = q.cc_rst;
    assign hart_run = q.run;
    assign hart_vector = q.vec;
    assign loop_code = q.loop;
    // Harts spin while the flag is clear; writing 1 to the scratch register exits
    assign loop_hold = ~q.scratch;
    assign boot_from_code_mem = q.code_mem;
    assign cc_clk_mhz = q.clk_mhz;
    assign cc_clk_src = q.clk_src;

endmodule : bms_sequencer

// *** bms_seq_asserts.sv ***
module bms_seq_asserts (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Watched ports
    input wire bms_pkg::bms_bus_t bus,
    input wire bms_pkg::bms_cert_t cert,
    input wire logic sig_req,
    input wire logic sig_done,
    input wire logic [383:0] sig_check_x,
    input wire logic hash_req,
    input wire logic hash_done,
    input wire logic [383:0] hash_value,
    input wire logic cc_reset,
    input wire logic [bms_pkg::HART_COUNT-1:0] hart_run,
    input wire logic [bms_pkg::HART_COUNT-1:0][63:0] hart_vector,
    input wire logic [31:0] loop_code,
    input wire logic loop_hold,
    input wire logic boot_from_code_mem,
    input wire logic [7:0] cc_clk_mhz,
    input wire logic [1:0] cc_clk_src
);
    // --------------------
    // Checks
    // --------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_sig_bad;
        sig_done && sig_check_x != cert.sig_r;
    endsequence
    sequence s_hash_bad;
        cc_reset && hash_done && hash_value != cert.ubl_hash;
    endsequence
    a_cfg_hold: assert property ($fell(rst) |-> cc_reset [*8])
        else $error("core reset dropped during configuration");
    a_clk_default: assert property ($fell(rst) |->
        cc_clk_mhz == bms_pkg::CC_CLK_MHZ &&
        cc_clk_src == bms_pkg::CLK_SRC_SYSCTRL)
        else $error("clock default wrong");
    a_held_idle: assert property (cc_reset |-> hart_run == '0)
        else $error("hart runs while held");
    a_release_run: assert property ($fell(cc_reset) |-> hart_run[0])
        else $error("release without monitor hart");
    a_loop_setup: assert property ($fell(cc_reset) && &hart_run &&
        !boot_from_code_mem |-> loop_code == bms_pkg::LOOP_CODE &&
        loop_hold && hart_vector ==
        {bms_pkg::HART_COUNT{bms_pkg::LOOP_BASE}})
        else $error("loop setup wrong");
    a_cert_vector: assert property ($fell(cc_reset) &&
        hart_run == 5'h01 |-> hart_vector == cert.vector)
        else $error("secure vectors wrong");
    a_scratch_exit: assert property (bus.wr && bus.wdata[0] &&
        bus.addr == bms_pkg::REG_SCRATCH |=> !loop_hold)
        else $error("loop not left");
    a_sig_gate: assert property (s_sig_bad |=> !hash_req)
        else $error("hash after bad signature");
    a_hash_gate: assert property (s_hash_bad |=> cc_reset [*4])
        else $error("release after bad hash");
    a_sig_pulse: assert property (sig_req |=> !sig_req)
        else $error("signature request too long");
    a_hash_order: assert property (hash_req |-> $past(sig_done))
        else $error("hash without signature");
endmodule : bms_seq_asserts

bind bms_sequencer bms_seq_asserts u_bms_seq_asserts (
    .sys_clk(sys_clk), .rst(rst), .bus(bus), .cert(cert),
    .sig_req(sig_req), .sig_done(sig_done), .sig_check_x(sig_check_x),
    .hash_req(hash_req), .hash_done(hash_done), .hash_value(hash_value),
    .cc_reset(cc_reset), .hart_run(hart_run), .hart_vector(hart_vector),
    .loop_code(loop_code), .loop_hold(loop_hold),
    .boot_from_code_mem(boot_from_code_mem),
    .cc_clk_mhz(cc_clk_mhz), .cc_clk_src(cc_clk_src)
);

// *** bms_cc_model.sv ***
module bms_cc_model (
    // Clock and scenario
    input wire logic sys_clk,
    input wire logic slow,
    input wire logic [383:0] sig_x,
    input wire logic [383:0] hash_x,
    // Engines
    input wire logic sig_req,
    output logic sig_done,
    output logic [383:0] sig_check_x,
    input wire logic hash_req,
    output logic hash_done,
    output logic [383:0] hash_value,
    // Harts
    input wire logic [4:0] hart_run,
    output logic app_release
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] sig_cnt = 4'h0;
    logic [3:0] hash_cnt = 4'h0;
    logic [1:0] boot_dly = 2'h0;
    // --------------------
    // Engines and monitor hart
    // --------------------
    always_ff @(posedge sys_clk) begin
        if (sig_req) begin
            sig_cnt <= slow ? 4'h7 : 4'h2;
        end else if (sig_cnt != 4'h0) begin
            sig_cnt <= sig_cnt - 4'h1;
        end
        if (hash_req) begin
            hash_cnt <= slow ? 4'h7 : 4'h2;
        end else if (hash_cnt != 4'h0) begin
            hash_cnt <= hash_cnt - 4'h1;
        end
        boot_dly <= {boot_dly[0], hart_run[0]};
    end
    // Result stands with done only, garbage otherwise
    assign sig_done = sig_cnt == 4'h1;
    assign sig_check_x = sig_done ? sig_x : ~sig_x;
    assign hash_done = hash_cnt == 4'h1;
    assign hash_value = hash_done ? hash_x : ~hash_x;
    assign app_release = boot_dly[1];
endmodule : bms_cc_model

// *** bms_sequencer_bench.sv ***
module bms_sequencer_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [63:0] SER = 64'h2000_0700;
    localparam logic [63:0] THR = 64'h2000_0600;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    bms_pkg::bms_bus_t bus = '0;
    logic prog_we = 1'b0;
    logic [2:0] prog_addr = 3'h0;
    logic [63:0] prog_data = 64'h0;
    logic cert_valid = 1'b1;
    bms_pkg::bms_cert_t cert = '0;
    logic slow = 1'b0;
    logic [383:0] sig_x = '0;
    logic [383:0] hash_x = '0;
    logic sig_req, sig_done, hash_req, hash_done, app_release;
    logic cc_reset, loop_hold, boot_from_code_mem;
    logic [383:0] sig_check_x, hash_value;
    logic [4:0] hart_run, first_run;
    logic [4:0][63:0] hart_vector, ev;
    logic [31:0] loop_code, rdata, got;
    logic [7:0] cc_clk_mhz;
    logic [1:0] cc_clk_src;
    logic [63:0] ser_t [6] = '{SER, 64'h0, 64'h5, SER, SER, SER};
    logic [63:0] ver_t [6] = '{THR, 64'h0, THR, THR - 1, THR, THR};
    logic [3:0] code_t [6] = '{4'h0, 4'h0, 4'h2, 4'h3, 4'h4, 4'h5};
    int err_total = 0;
    int checks = 0;

    bms_sequencer u_bms_sequencer (
        .sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata),
        .prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data),
        .cert_valid(cert_valid), .cert(cert), .sig_req(sig_req),
        .sig_done(sig_done), .sig_check_x(sig_check_x),
        .hash_req(hash_req), .hash_done(hash_done),
        .hash_value(hash_value), .app_release(app_release),
        .cc_reset(cc_reset), .hart_run(hart_run),
        .hart_vector(hart_vector), .loop_code(loop_code),
        .loop_hold(loop_hold), .boot_from_code_mem(boot_from_code_mem),
        .cc_clk_mhz(cc_clk_mhz), .cc_clk_src(cc_clk_src)
    );
    bms_cc_model u_bms_cc_model (
        .sys_clk(sys_clk), .slow(slow), .sig_x(sig_x), .hash_x(hash_x),
        .sig_req(sig_req), .sig_done(sig_done),
        .sig_check_x(sig_check_x), .hash_req(hash_req),
        .hash_done(hash_done), .hash_value(hash_value),
        .hart_run(hart_run), .app_release(app_release)
    );

    // --------------------
    // Tasks
    // --------------------
    task chk(input string what, input logic [319:0] exp,
             input logic [319:0] seen);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1 got = rdata;
    endtask : rd
    task prog(input logic [2:0] a, input logic [63:0] d);
        @(posedge sys_clk);
        prog_we <= 1'b1;
        prog_addr <= a;
        prog_data <= d;
        @(posedge sys_clk);
        prog_we <= 1'b0;
    endtask : prog
    // Bounded: failed boots never release
    task wait_run;
        for (int i = 0; i < 60 && cc_reset !== 1'b0; i++) begin
            @(posedge sys_clk);
            #1;
        end
        first_run = hart_run;
        repeat (6) @(posedge sys_clk);
        #1;
    endtask : wait_run
    task boot(input logic [7:0] m);
        prog(3'h0, {56'h0, m});
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        wait_run();
    endtask : boot
    task print_verdict;
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    // --------------------
    // Scenarios
    // --------------------
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (4000) @(posedge sys_clk);
        err_total++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        prog(3'h0, 64'h0);
        rd(bms_pkg::REG_CLKCFG);
        chk("clkcfg", 320'h50, got);
        chk("clk port", 320'h50, {cc_clk_src, cc_clk_mhz});
        @(posedge sys_clk);
        #1;
        chk("rdata clear", 320'h0, rdata);
        chk("cfg hold", 320'h1, cc_reset);
        for (int h = 1; h < 8; h++) begin
            prog(3'(h), 64'h2000_0000 + 64'(h * 256));
        end
        wait_run();
        chk("noboot run", 320'h1f, hart_run);
        chk("loop vec", {5{bms_pkg::LOOP_BASE}}, hart_vector);
        chk("loop code", bms_pkg::LOOP_CODE, loop_code);
        chk("loop hold", 320'h1, loop_hold);
        wr(bms_pkg::REG_MODE, 32'h1);
        wr(bms_pkg::REG_SCRATCH, 32'h1);
        rd(bms_pkg::REG_MODE);
        chk("mode ro", 320'h0, got);
        chk("loop exit", 320'h0, loop_hold);
        rd(4'h2);
        chk("unmapped", 320'h0, got);
        boot(8'h01);
        for (int h = 0; h < 5; h++) begin
            ev[h] = 64'h2000_0000 + 64'((h + 1) * 256);
        end
        chk("std vec", ev, hart_vector);
        chk("std run", 320'h1f, hart_run);
        chk("code mem", 320'h1, boot_from_code_mem);
        boot(8'h03);
        rd(bms_pkg::REG_STATUS);
        chk("bad mode", 320'h1, got[7:4]);
        chk("bad held", 320'h1, cc_reset);
        for (int t = 0; t < 6; t++) begin
            cert.serial = ser_t[t];
            cert.version = ver_t[t];
            cert.sig_r = 384'h5eed + 384'(t);
            cert.ubl_hash = 384'hab + 384'(t);
            for (int h = 0; h < 5; h++) begin
                cert.vector[h] = 64'h3000_0000 + 64'(h * 16 + t);
            end
            sig_x = code_t[t] == 4'h4 ? ~cert.sig_r : cert.sig_r;
            hash_x = code_t[t] == 4'h5 ? ~cert.ubl_hash : cert.ubl_hash;
            slow = t[0];
            boot(8'h02);
            rd(bms_pkg::REG_STATUS);
            chk("fail code", code_t[t], got[7:4]);
            if (code_t[t] == 4'h0) begin
                chk("monitor first", 320'h1, first_run);
                chk("cert vec", cert.vector, hart_vector);
                chk("app start", 320'h1f, hart_run);
            end else begin
                chk("secure held", 320'h1, cc_reset);
            end
        end
        print_verdict();
    end
endmodule : bms_sequencer_bench
